// >>> rtl/psag_addr_mux.sv
// Combinational program address former for fetch, table and visibility accesses
module psag_addr_mux
    import psag_pkg::*;
(
    input  wire psag_acc_t          acc_kind,      // Access type
    input  wire logic [PC_W-1:0]    pc,            // Program counter
    input  wire logic [PAGE_W-1:0]  table_page,    // Table page register
    input  wire logic [PAGE_W-1:0]  vis_page,      // Visibility page register
    input  wire logic [EA_W-1:0]    eff_addr,      // Data effective address
    output logic      [PADDR_W-1:0] prog_addr      // Formed program address
);
    // Address selection per access kind
    always_comb begin
        case (acc_kind)
            PSAG_ACC_FETCH: prog_addr = {1'b0, pc[PC_W-1:1], 1'b0};
            PSAG_ACC_TABLE: prog_addr = {table_page, eff_addr};
            PSAG_ACC_VIS:   prog_addr = {1'b0, vis_page[PAGE_W-1:1], vis_page[0],
                                         eff_addr[EA_TOP-1:0]};
            default:        prog_addr = '0;
        endcase
    end
endmodule

// >>> rtl/psag_pkg.sv
// Constants and types for the program space address generator
// Functional notes
// - Visibility mode drops data address bit 15; page bit 0 supplies program bit 15.
// - Visibility page takes any written value; only all zeros (program) or all ones (EEPROM) are legal, others set page_err.
// - EEPROM words are 16 bits; one low-word table read returns a whole word.
// - EEPROM locations are also readable through the visibility window.
package psag_pkg;
    localparam int PADDR_W = 24;
    localparam int EA_W    = 16;
    localparam int PAGE_W  = 8;
    localparam int PC_W    = 23;
    localparam int WORD_W  = 16;
    localparam int HI_W    = 8;
    localparam int EA_TOP  = 15;
    localparam logic [PAGE_W-1:0] PAGE_PROG   = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_EEPROM = 8'hff;
    localparam logic [PAGE_W-1:0] PAGE_RST    = 8'h00;
    typedef enum logic [1:0] {
        PSAG_IDLE,
        PSAG_WAIT,
        PSAG_DONE
    } psag_state_t;
    typedef enum logic [1:0] {
        PSAG_ACC_FETCH,
        PSAG_ACC_TABLE,
        PSAG_ACC_VIS
    } psag_acc_t;
endpackage

// >>> rtl/psag_top.sv
// Program space address generator: table, visibility and fetch addressing
//
// The strobed register port and the placing of the registers were left to the implementer.
module psag_top
    import psag_pkg::*;
(
    input  wire logic               clk,            // System clock, 10 MHz
    input  wire logic               nrst,           // Async reset, active low
    input  wire logic               ce,             // Clock enable, freezes state
    input  wire logic               page_wr,        // Write table page register
    input  wire logic               vis_wr,         // Write visibility page register
    input  wire logic [PAGE_W-1:0]  page_wdata,     // Page write data
    input  wire logic               fetch_req,      // Instruction fetch request
    input  wire logic [PC_W-1:0]    pc,             // Program counter
    input  wire logic               tbl_rd,         // Low-word table read
    input  wire logic               tbl_rd_hi,      // High-word table read
    input  wire logic               vis_rd,         // Visibility window read
    input  wire logic [EA_W-1:0]    eff_addr,       // Data effective address
    output logic                    mem_req,        // Memory request
    output logic                    mem_eeprom,     // Request targets EEPROM
    output logic      [PADDR_W-1:0] mem_addr,       // Program space address
    input  wire logic               mem_ack,        // Memory data valid
    input  wire logic [WORD_W-1:0]  mem_rdata,      // Low word from memory
    input  wire logic [HI_W-1:0]    mem_rdata_hi,   // Upper byte from flash
    output logic                    rd_valid,       // Read data valid pulse
    output logic      [WORD_W-1:0]  rd_data,        // Read data to core
    output logic      [PAGE_W-1:0]  table_page_out, // Table page readback
    output logic      [PAGE_W-1:0]  vis_page_out,   // Visibility page readback
    output logic                    page_err        // Illegal visibility page written
);

    // Sequencer and access decode
    psag_state_t            state_reg;      // Current sequencer state
    psag_state_t            state_next;     // Next sequencer state
    psag_acc_t              kind;           // Winning access kind
    logic                   start;          // Request taken this cycle
    logic                   ack_seen;       // Memory answer taken this cycle
    logic [PADDR_W-1:0]     formed;         // Address from the former

    // Page group
    logic [PAGE_W-1:0]      tpage_reg;      // Table page register
    logic [PAGE_W-1:0]      tpage_next;
    logic [PAGE_W-1:0]      vpage_reg;      // Visibility page register
    logic [PAGE_W-1:0]      vpage_next;
    logic                   err_reg;        // Illegal visibility page flag
    logic                   err_next;

    // Request group
    logic                   req_reg;        // Memory request
    logic                   req_next;
    logic                   ee_reg;         // Request targets the EEPROM
    logic                   ee_next;
    logic                   hi_reg;         // High-word table read
    logic                   hi_next;
    logic [PADDR_W-1:0]     addr_reg;       // Address held for the memory
    logic [PADDR_W-1:0]     addr_next;

    // Answer group
    logic                   vld_reg;        // Read data valid pulse
    logic                   vld_next;
    logic [WORD_W-1:0]      data_reg;       // Read data to the core
    logic [WORD_W-1:0]      data_next;

    // Fetch wins over data side, then visibility, then table
    always_comb begin
        if (fetch_req) begin
            kind = PSAG_ACC_FETCH;
        end else if (vis_rd) begin
            kind = PSAG_ACC_VIS;
        end else begin
            kind = PSAG_ACC_TABLE;
        end
    end

    psag_addr_mux u_mux (
        .acc_kind   (kind),
        .pc         (pc),
        .table_page (tpage_reg),
        .vis_page   (vpage_reg),
        .eff_addr   (eff_addr),
        .prog_addr  (formed)
    );

    // Requests only count while idle; busy ones are dropped, not queued
    assign start    = (state_reg == PSAG_IDLE) && (fetch_req || tbl_rd || tbl_rd_hi || vis_rd);
    // Answer only counts while waiting
    assign ack_seen = (state_reg == PSAG_WAIT) && mem_ack;

    // Page registers; a write lands even while a request is in flight
    always_comb begin
        tpage_next = tpage_reg;
        vpage_next = vpage_reg;
        err_next   = err_reg;
        // table page set up before reads
        if (page_wr) begin
            tpage_next = page_wdata;
        end
        if (vis_wr) begin
            vpage_next = page_wdata;
            err_next   = (page_wdata != PAGE_PROG) && (page_wdata != PAGE_EEPROM);
        end
    end

    // Page flops; ce low holds them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tpage_reg <= PAGE_RST;
            vpage_reg <= PAGE_RST;
            err_reg   <= 1'b0;
        end else if (ce) begin
            tpage_reg <= tpage_next;
            vpage_reg <= vpage_next;
            err_reg   <= err_next;
        end
    end

    // Sequencer: idle, wait for the memory, one done cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSAG_IDLE: begin
                if (start) begin
                    state_next = PSAG_WAIT;
                end
            end
            PSAG_WAIT: begin
                if (mem_ack) begin
                    state_next = PSAG_DONE;
                end
            end
            // Done cycle keeps a new request off the rd_valid cycle
            PSAG_DONE: begin
                state_next = PSAG_IDLE;
            end
            default: begin
                state_next = PSAG_IDLE;
            end
        endcase
    end

    // Sequencer flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= PSAG_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Request fields latched when taken, held until the memory answers
    always_comb begin
        req_next  = req_reg;
        ee_next   = ee_reg;
        hi_next   = hi_reg;
        addr_next = addr_reg;
        if (start) begin
            req_next  = 1'b1;
            addr_next = formed;
            hi_next   = tbl_rd_hi && !fetch_req && !vis_rd;
            if (fetch_req) begin
                ee_next = 1'b0;
            end else if (vis_rd) begin
                ee_next = (vpage_reg == PAGE_EEPROM);
            end else begin
                ee_next = (tpage_reg == PAGE_EEPROM);
            end
        end else if (ack_seen) begin
            req_next  = 1'b0;
        end
    end

    // Request flops; a steady address spares the memory a moving target
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_reg  <= 1'b0;
            ee_reg   <= 1'b0;
            hi_reg   <= 1'b0;
            addr_reg <= '0;
        end else if (ce) begin
            req_reg  <= req_next;
            ee_reg   <= ee_next;
            hi_reg   <= hi_next;
            addr_reg <= addr_next;
        end
    end

    // Answer pulse and data; EEPROM has no upper byte, so a high read gives zero
    always_comb begin
        vld_next  = 1'b0;
        data_next = data_reg;
        if (ack_seen) begin
            vld_next = 1'b1;
            // EEPROM word complete in low read
            if (!hi_reg) begin
                data_next = mem_rdata;
            end else if (ee_reg) begin
                data_next = '0;
            end else begin
                data_next = {{(WORD_W-HI_W){1'b0}}, mem_rdata_hi};
            end
        end
    end

    // Answer flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vld_reg  <= 1'b0;
            data_reg <= '0;
        end else if (ce) begin
            vld_reg  <= vld_next;
            data_reg <= data_next;
        end
    end

    // Outputs straight from flops
    assign mem_req        = req_reg;
    assign mem_eeprom     = ee_reg;
    assign mem_addr       = addr_reg;
    assign rd_valid       = vld_reg;
    assign rd_data        = data_reg;
    assign table_page_out = tpage_reg;
    assign vis_page_out   = vpage_reg;
    assign page_err       = err_reg;
endmodule

// >>> sim/psag_chk.sv
// Port checker for the program space address generator
module psag_chk
    import psag_pkg::*;
(
    input wire logic               clk,            // Clock
    input wire logic               nrst,           // Reset, low
    input wire logic               ce,             // Enable
    input wire logic               fetch_req,      // Fetch
    input wire logic [PC_W-1:0]    pc,             // Counter
    input wire logic               tbl_rd,         // Table read
    input wire logic               vis_rd,         // Window read
    input wire logic [EA_W-1:0]    eff_addr,       // Data address
    input wire logic               mem_req,        // Request
    input wire logic               mem_eeprom,     // EEPROM target
    input wire logic [PADDR_W-1:0] mem_addr,       // Address
    input wire logic               mem_ack,        // Ack
    input wire logic               rd_valid,       // Data valid
    input wire logic [PAGE_W-1:0]  table_page_out, // Table page
    input wire logic [PAGE_W-1:0]  vis_page_out,   // Window page
    input wire logic               page_err        // Bad page
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Idle and enabled, so a request is taken
    wire take = ce && !mem_req && !rd_valid;
    AST_FETCH: assert property (take && fetch_req |=> mem_req &&
        mem_addr == {1'b0, $past(pc) & 23'h7ffffe}) else $error("fetch address wrong");
    AST_VIS: assert property (take && vis_rd && !fetch_req |=> mem_addr ==
        ({1'b0, $past(vis_page_out), 15'h0} | {8'h00, $past(eff_addr) & 16'h7fff})
        && mem_eeprom == ($past(vis_page_out) == PAGE_EEPROM)) else $error("window wrong");
    AST_TBL: assert property (take && tbl_rd && !fetch_req && !vis_rd |=>
        mem_addr == {$past(table_page_out), $past(eff_addr)}) else $error("table wrong");
    AST_ACK: assert property (mem_req && mem_ack && ce |=> rd_valid && !mem_req)
        else $error("ack not answered");
    AST_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request dropped");
    AST_PGERR: assert property (page_err == (vis_page_out != PAGE_PROG &&
        vis_page_out != PAGE_EEPROM)) else $error("page flag wrong");
endmodule

// >>> sim/psag_mem_model.sv
// Memory model that answers requests after a wait picked by the address
module psag_mem_model
    import psag_pkg::*;
(
    input  wire logic               clk,         // Clock
    input  wire logic               mem_req,     // Request
    input  wire logic [PADDR_W-1:0] mem_addr,    // Address
    output logic                    mem_ack,     // Data valid
    output logic      [WORD_W-1:0]  mem_rdata,   // Low word
    output logic      [HI_W-1:0]    mem_rdata_hi // Upper byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]        wait_cnt = 2'h0;
    logic [WORD_W-1:0] word;
    assign word         = mem_addr[15:0] ^ {2{mem_addr[23:16]}};
    // Low word off the ack cycle is inverted and the upper byte lacks its 5a mask, so stale reads show
    assign mem_rdata    = mem_ack ? word : ~word;
    assign mem_rdata_hi = mem_ack ? mem_addr[7:0] ^ 8'h5a : mem_addr[7:0];
    // Waits of 0 to 3 cycles give prompt and slow answers
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (!mem_req || mem_ack) wait_cnt <= 2'h0;
        else if (wait_cnt == mem_addr[2:1]) mem_ack <= 1'b1;
        else wait_cnt <= wait_cnt + 2'h1;
    end
endmodule

// >>> sim/tb.sv
// Bench: random table, window and fetch accesses against the memory model
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module tb
    import psag_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, ce = 1, page_wr = 0, vis_wr = 0, fetch_req = 0;
    logic tbl_rd = 0, tbl_rd_hi = 0, vis_rd = 0, mem_req, mem_eeprom, mem_ack, rd_valid;
    logic              page_err;
    logic [PAGE_W-1:0] page_wdata = 8'h00, table_page_out, vis_page_out, tp, vp;
    logic [PC_W-1:0]   pc = 23'h0;
    logic [EA_W-1:0]   eff_addr = 16'h0;
    logic [23:0]       mem_addr, a, b;
    logic [15:0]       mem_rdata, rd_data;
    logic [7:0]        mem_rdata_hi;
    logic [31:0]       seed = 32'h995a3095, r;
    int                fail_count = 0, tests_run = 0, cycles = 0, i;
    psag_top u_dut (
        .clk            (clk),
        .nrst           (nrst),
        .ce             (ce),
        .page_wr        (page_wr),
        .vis_wr         (vis_wr),
        .page_wdata     (page_wdata),
        .fetch_req      (fetch_req),
        .pc             (pc),
        .tbl_rd         (tbl_rd),
        .tbl_rd_hi      (tbl_rd_hi),
        .vis_rd         (vis_rd),
        .eff_addr       (eff_addr),
        .mem_req        (mem_req),
        .mem_eeprom     (mem_eeprom),
        .mem_addr       (mem_addr),
        .mem_ack        (mem_ack),
        .mem_rdata      (mem_rdata),
        .mem_rdata_hi   (mem_rdata_hi),
        .rd_valid       (rd_valid),
        .rd_data        (rd_data),
        .table_page_out (table_page_out),
        .vis_page_out   (vis_page_out),
        .page_err       (page_err)
    );
    psag_mem_model u_mem (
        .clk          (clk),
        .mem_req      (mem_req),
        .mem_addr     (mem_addr),
        .mem_ack      (mem_ack),
        .mem_rdata    (mem_rdata),
        .mem_rdata_hi (mem_rdata_hi)
    );
    initial forever #50 clk = ~clk;
    function automatic logic [15:0] fw(input logic [23:0] x);
        return x[15:0] ^ {2{x[23:16]}};
    endfunction
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic setpg(input logic [7:0] v, input logic vis);
        @(posedge clk);
        page_wr    <= !vis;
        vis_wr     <= vis;
        page_wdata <= v;
        @(posedge clk);
        page_wr <= 1'b0;
        vis_wr  <= 1'b0;
        #1;
    endtask
    // Kind 0 table low, 1 table high, 2 window, 3 fetch
    task automatic go(input int k, input logic [22:0] v, input logic [23:0] ea,
                      input logic [15:0] ed);
        int n;
        n = 0;
        @(posedge clk);
        {fetch_req, vis_rd, tbl_rd_hi, tbl_rd} <= 4'h1 << k;
        pc       <= v;
        eff_addr <= v[15:0];
        @(posedge clk);
        {fetch_req, vis_rd, tbl_rd_hi, tbl_rd} <= 4'h0;
        #1 `CHK(mem_addr, ea)
        while (rd_valid !== 1'b1 && n < 9) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, ed)
    endtask
    // Hang guard, well above the fewer than 800 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        setpg(8'h3c, 1'b1);
        `CHK(page_err, 1'b1)
        for (i = 0; i < 24; i++) begin
            r  = $random(seed);
            tp = (i == 0) ? 8'hff : r[7:0];
            vp = {8{r[8]}};
            a  = {tp, r[31:16]};
            setpg(tp, 1'b0);
            setpg(vp, 1'b1);
            `CHK(page_err, 1'b0)
            b  = {1'b0, vp, a[14:0]};
            go(0, {7'h00, a[15:0]}, a, fw(a));
            go(1, {7'h00, a[15:0]}, a, (tp == 8'hff) ? 16'h0 : {8'h00, a[7:0] ^ 8'h5a});
            `CHK(mem_eeprom, tp == PAGE_EEPROM)
            go(2, {7'h00, a[15:0] | 16'h8000}, b, fw(b));
            `CHK(mem_eeprom, vp == PAGE_EEPROM)
            go(3, r[30:8], {1'b0, r[30:9], 1'b0}, fw({1'b0, r[30:9], 1'b0}));
            `CHK(mem_eeprom, 1'b0)
        end
        // Clock enable low: page write and table read are both frozen
        @(posedge clk);
        ce         <= 1'b0;
        page_wr    <= 1'b1;
        tbl_rd     <= 1'b1;
        page_wdata <= ~tp;
        @(posedge clk);
        page_wr <= 1'b0;
        tbl_rd  <= 1'b0;
        #1 `CHK(table_page_out, tp)
        `CHK(mem_req, 1'b0)
        // Reset in mid-run returns both pages to their reset value
        @(posedge clk);
        ce   <= 1'b1;
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1 `CHK(table_page_out, PAGE_RST)
        `CHK(vis_page_out, PAGE_RST)
        go(0, 23'h001234, {PAGE_RST, 16'h1234}, fw({PAGE_RST, 16'h1234}));
        print_verdict();
    end
endmodule
bind psag_top psag_chk u_chk (
    .clk            (clk),
    .nrst           (nrst),
    .ce             (ce),
    .fetch_req      (fetch_req),
    .pc             (pc),
    .tbl_rd         (tbl_rd),
    .vis_rd         (vis_rd),
    .eff_addr       (eff_addr),
    .mem_req        (mem_req),
    .mem_eeprom     (mem_eeprom),
    .mem_addr       (mem_addr),
    .mem_ack        (mem_ack),
    .rd_valid       (rd_valid),
    .table_page_out (table_page_out),
    .vis_page_out   (vis_page_out),
    .page_err       (page_err)
);
